// file: hw/atg_top.sv
// Acquisition timing generator: counters, decoders, sync, interrupts
// How it works
// - 14-bit line pixel counter with pulse decoders.
// - sync, active and aux line signals have start and end, one-pixel resolution.
// - line sync, active window, period pulse, two aux pulses driven.
// - line counter resets on external or composite sync.
// - composite sync separated into line sync, equalization ignored.
// - 14-bit frame line counter with one-line decoders.
// - frame sync, active window, period pulse, two aux pulses driven.
// - vertical source: ext sync, ext reset, software, free running.
// - external trigger starts a frame; continuous mode for line scan.
// - frame sync found in composite sync by long pulse width.
// - four active-high interrupts, each with its own selector.
// - timing sources: aux pulses, active edges, line sync, sync edges.
// - strobe, aux edges, sync error, FIFO done sources.
// - 16-bit tachometer of line rate refreshed every 1.64 ms.
// - aux inputs used as sources, three aux outputs driven.
// - free-running line and frame counters with capture.
// - fire command starts acquisition; strobe exclusion zone.
`timescale 1ns/1ps
`default_nettype none
module atg_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdData,
  // Pins in
  input  wire logic        lineSyncIn,
  input  wire logic        compSyncIn,
  input  wire logic        frameSyncIn,
  input  wire logic        frameResetIn,
  input  wire logic        strobeIn,
  input  wire logic        fireIn,
  input  wire logic        auxInputDiff,
  input  wire logic        auxInputSingle,
  input  wire logic        fifoDone,
  // Timing outputs
  output logic             lineSyncOut,
  output logic             lineActiveWindow,
  output logic             linePeriodPulse,
  output logic             lineAuxPulse1,
  output logic             lineAuxPulse2,
  output logic             frameSyncOut,
  output logic             frameActiveWindow,
  output logic             framePeriodPulse,
  output logic             frameAuxPulse1,
  output logic             frameAuxPulse2,
  output logic             strobeInhibit,
  // Aux and interrupts
  output logic             auxOutputDiff,
  output logic             auxOutputSingleA,
  output logic             auxOutputSingleB,
  output logic      [3:0]  irq
);
  localparam int W = atg_pkg::CNT_W;
  // Registers
  logic [31:0] ctrl, next_ctrl;
  logic [31:0] hreg [1:5];
  logic [31:0] vreg [6:10];
  logic [15:0] irqSel, next_irqSel;
  logic [2:0]  auxOut, next_auxOut;
  logic [31:0] excl, next_excl;
  logic [31:0] rdData, next_rdData;
  logic        softFrame;
  // Input synchronisers, two flops each
  logic [8:0] syncA, syncB;
  always_ff @(posedge clk) begin
    syncA <= {fifoDone, auxInputSingle, auxInputDiff, fireIn, strobeIn,
              frameResetIn, frameSyncIn, compSyncIn, lineSyncIn};
    syncB <= syncA;
  end
  logic [8:0] sPrev;
  always_ff @(posedge clk) sPrev <= syncB;
  wire logic [8:0] rise = syncB & ~sPrev;
  wire logic [8:0] fall = ~syncB & sPrev;

  // Composite sync processor: width measure separates line and frame sync
  logic [W-1:0] cw;
  logic         csLine, csFrame, syncErr;
  always_ff @(posedge clk) begin
    if (reset || !syncB[1]) cw <= '0;
    else if (cw != atg_pkg::CNT_MAX) cw <= cw + 1'b1;
  end
  wire logic strip = ctrl[atg_pkg::C_STRIP];
  wire logic [W-1:0] minW = strip ? W'(atg_pkg::HSYNC_LONG_CYC)
                                  : W'(atg_pkg::SEP_CYC);
  // Short pulses dropped when stripping; very long pulse marks frame sync
  assign csLine  = fall[1] && cw >= minW && cw < (minW << 3);
  assign csFrame = fall[1] && cw >= (minW << 3);

  // Line counter
  logic [W-1:0] hCnt, next_hCnt, vCnt, next_vCnt;
  logic         lineEnd, hExtRst, vExtRst, running, next_running;
  wire logic [1:0] hsrc = ctrl[atg_pkg::C_HSRC +: 2];
  always_comb begin
    hExtRst = (hsrc == 2'd1 && rise[0]) || (hsrc == 2'd2 && csLine);
    lineEnd = hCnt >= hreg[1][W-1:0];
    if (hExtRst) next_hCnt = '0;
    else if (lineEnd) next_hCnt = '0;
    else next_hCnt = hCnt + 1'b1;
  end
  wire logic lineStart = hExtRst || lineEnd;
  // Frame counter source
  atg_pkg::atg_vsrc_t vsrc;
  assign vsrc = atg_pkg::atg_vsrc_t'(ctrl[atg_pkg::C_VSRC +: 2]);
  always_comb begin
    unique case (vsrc)
      atg_pkg::VS_EXTSYNC:  vExtRst = rise[2] || csFrame;
      atg_pkg::VS_EXTRESET: vExtRst = rise[3];
      atg_pkg::VS_SOFT:     vExtRst = softFrame;
      atg_pkg::VS_FREE:     vExtRst = 1'b0;
    endcase
    next_running = running;
    if (!ctrl[atg_pkg::C_TRIG]) next_running = 1'b1;
    else if (rise[5]) next_running = 1'b1;
    else if (lineStart && vCnt >= vreg[6][W-1:0]) next_running = 1'b0;
    next_vCnt = vCnt;
    if (vExtRst) next_vCnt = '0;
    else if (lineStart && running) begin
      if (ctrl[atg_pkg::C_CONT]) next_vCnt = '0;
      else if (vCnt >= vreg[6][W-1:0]) next_vCnt = '0;
      else next_vCnt = vCnt + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      hCnt <= '0;
      vCnt <= '0;
      running <= 1'b0;
    end else begin
      hCnt <= next_hCnt;
      vCnt <= next_vCnt;
      running <= next_running;
    end
  end

  // Window decoders: each reg holds end[29:16] and start[13:0]
  function automatic logic win(input logic [W-1:0] c, input logic [31:0] r);
    win = c >= r[W-1:0] && c < r[16 +: W];
  endfunction
  logic [4:0] hDec, vDec;
  logic       contAct;
  always_comb begin
    hDec[0] = win(hCnt, hreg[2]);
    hDec[1] = win(hCnt, hreg[3]);
    hDec[2] = lineEnd;
    hDec[3] = win(hCnt, hreg[4]);
    hDec[4] = win(hCnt, hreg[5]);
    contAct = ctrl[atg_pkg::C_CONT] && running;
    vDec[0] = win(vCnt, vreg[7]);
    vDec[1] = contAct || (running && win(vCnt, vreg[8]));
    vDec[2] = lineStart && vCnt >= vreg[6][W-1:0];
    vDec[3] = win(vCnt, vreg[9]);
    vDec[4] = win(vCnt, vreg[10]);
  end
  logic [4:0] hOut, vOut, vOutP;
  always_ff @(posedge clk) begin
    if (reset) begin
      hOut <= '0;
      vOut <= '0;
      vOutP <= '0;
    end else begin
      hOut <= hDec;
      vOut <= vDec;
      vOutP <= vOut;
    end
  end
  assign {lineAuxPulse2, lineAuxPulse1, linePeriodPulse,
          lineActiveWindow, lineSyncOut} = hOut;
  assign {frameAuxPulse2, frameAuxPulse1, framePeriodPulse,
          frameActiveWindow, frameSyncOut} = vOut;
  wire logic [4:0] vRise = vOut & ~vOutP;
  wire logic [4:0] vFall = ~vOut & vOutP;
  // Strobe exclusion zone over lines excl start..end
  always_ff @(posedge clk) begin
    if (reset) strobeInhibit <= 1'b0;
    else strobeInhibit <= win(vCnt, excl);
  end

  // Interrupt sources and selectors
  logic [13:0] src;
  always_comb begin
    src = '0;
    src[atg_pkg::IS_FRAME_AUX_PULSE_1]     = vRise[3];
    src[atg_pkg::IS_FRAME_AUX_PULSE_2]     = vRise[4];
    src[atg_pkg::IS_VACT_ON]   = vRise[1];
    src[atg_pkg::IS_VACT_OFF]  = vFall[1];
    src[atg_pkg::IS_STROBE]    = rise[4];
    src[atg_pkg::IS_HSYNC]     = hDec[0] && !hOut[0];
    src[atg_pkg::IS_VSYNC_ON]  = vRise[0];
    src[atg_pkg::IS_VSYNC_OFF] = vFall[0];
    src[atg_pkg::IS_AUX_RISE]  = rise[7];
    src[atg_pkg::IS_AUX_FALL]  = fall[7];
    src[atg_pkg::IS_SYNCERR]   = syncErr;
    src[atg_pkg::IS_FIFODONE]  = rise[8];
    src[atg_pkg::IS_AUXDIFF]   = rise[6];
  end
  // Sync error: external line sync arriving off the expected end
  assign syncErr = hsrc != 2'd0 && hExtRst && !lineEnd;
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_irq
    always_ff @(posedge clk) begin
      if (reset) irq[gi] <= 1'b0;
      // Codes above none select nothing, never an undefined source bit
      else irq[gi] <= (irqSel[gi*4 +: 4] < 4'hE) &&
                      src[irqSel[gi*4 +: 4]];
    end
  end
  // Free-running counters and capture
  logic [31:0] lineFree, frameFree, lineCap, frameCap;
  logic        capEv;
  always_comb begin
    unique case (ctrl[atg_pkg::C_CAPS +: 2])
      2'd0: capEv = rise[4];
      2'd1: capEv = rise[7];
      2'd2: capEv = rise[6];
      2'd3: capEv = rise[5];
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      lineFree <= '0;
      frameFree <= '0;
      lineCap <= '0;
      frameCap <= '0;
    end else begin
      lineFree <= lineFree + {31'h0, lineStart};
      frameFree <= frameFree + {31'h0, vDec[2]};
      if (capEv) begin
        lineCap <= lineFree;
        frameCap <= frameFree;
      end
    end
  end
  // Tachometer: counts selected line edges per 1.64 ms gate
  logic [31:0] tGate;
  logic [15:0] tCnt, tach;
  logic        tEv;
  always_comb begin
    unique case (ctrl[atg_pkg::C_TACHS +: 2])
      2'd0: tEv = rise[0];
      2'd1: tEv = csLine;
      2'd2: tEv = rise[6];
      2'd3: tEv = lineStart;
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      tGate <= '0;
      tCnt <= '0;
      tach <= '0;
    end else if (tGate == 32'(atg_pkg::TACH_CYC - 1)) begin
      tGate <= '0;
      tach <= tCnt;
      tCnt <= {15'h0, tEv};
    end else begin
      tGate <= tGate + 1'b1;
      if (tCnt != 16'hFFFF) tCnt <= tCnt + {15'h0, tEv};
    end
  end
  assign {auxOutputSingleB, auxOutputSingleA, auxOutputDiff} = auxOut;

  // Register write and read decode
  assign softFrame = regWrite && regAddr == atg_pkg::A_CMD && regWrData[0];
  always_comb begin
    next_ctrl = ctrl;
    next_irqSel = irqSel;
    next_auxOut = auxOut;
    next_excl = excl;
    if (regWrite) begin
      unique case (regAddr)
        atg_pkg::A_CTRL:   next_ctrl = regWrData;
        atg_pkg::A_IRQSEL: next_irqSel = regWrData[15:0];
        atg_pkg::A_AUXOUT: next_auxOut = regWrData[2:0];
        atg_pkg::A_EXCL:   next_excl = regWrData;
        default: ;
      endcase
    end
    next_rdData = '0;
    if (regRead) begin
      if (regAddr >= atg_pkg::A_HPER && regAddr <= atg_pkg::A_LINE_AUX_PULSE_2)
        next_rdData = hreg[regAddr[2:0]];
      else if (regAddr >= atg_pkg::A_VPER && regAddr <= atg_pkg::A_FRAME_AUX_PULSE_2)
        next_rdData = vreg[regAddr[3:0]];
      else unique case (regAddr)
        atg_pkg::A_CTRL:   next_rdData = ctrl;
        atg_pkg::A_IRQSEL: next_rdData = {16'h0, irqSel};
        atg_pkg::A_AUXOUT: next_rdData = {29'h0, auxOut};
        atg_pkg::A_EXCL:   next_rdData = excl;
        atg_pkg::A_STAT:   next_rdData = {running, 1'b0, vCnt, 2'h0, hCnt};
        atg_pkg::A_TACH:   next_rdData = {16'h0, tach};
        atg_pkg::A_LCAP:   next_rdData = lineCap;
        atg_pkg::A_FCAP:   next_rdData = frameCap;
        default:           next_rdData = '0;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl <= atg_pkg::CTRL_RST;
      irqSel <= 16'hDDDD;
      auxOut <= '0;
      excl <= '0;
      rdData <= '0;
      for (int i = 1; i <= 5; i++) hreg[i] <= atg_pkg::ZERO32;
      for (int i = 6; i <= 10; i++) vreg[i] <= atg_pkg::ZERO32;
    end else begin
      ctrl <= next_ctrl;
      irqSel <= next_irqSel;
      auxOut <= next_auxOut;
      excl <= next_excl;
      rdData <= next_rdData;
      for (int i = 1; i <= 5; i++)
        if (regWrite && regAddr == 8'(i)) hreg[i] <= regWrData;
      for (int i = 6; i <= 10; i++)
        if (regWrite && regAddr == 8'(i)) vreg[i] <= regWrData;
    end
  end
  assign regRdData = rdData;
endmodule // atg_top
`default_nettype wire

// file: hw/atg_pkg.sv
// Package: constants for the acquisition timing generator
package atg_pkg;
  localparam int CNT_W = 14;
  localparam int REG_W = 8;
  localparam logic [13:0] CNT_MAX = 14'h3FFF; // 16,383 counts
  localparam real CLK_MHZ = 125.0;
  localparam real TACH_MS = 1.64;
  localparam int TACH_CYC = int'(TACH_MS * CLK_MHZ * 1000.0);
  localparam real HSYNC_LONG_NS = 200.0;
  localparam int HSYNC_LONG_CYC = int'((HSYNC_LONG_NS * CLK_MHZ) / 1000.0);
  localparam real SEP_NS = 25.0;
  localparam int SEP_CYC = int'((SEP_NS * CLK_MHZ + 999.0) / 1000.0);
  // Register offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_HPER = 8'h01;
  localparam logic [7:0] A_HSYNC = 8'h02;
  localparam logic [7:0] A_HACT = 8'h03;
  localparam logic [7:0] A_LINE_AUX_PULSE_1 = 8'h04;
  localparam logic [7:0] A_LINE_AUX_PULSE_2 = 8'h05;
  localparam logic [7:0] A_VPER = 8'h06;
  localparam logic [7:0] A_VSYNC = 8'h07;
  localparam logic [7:0] A_VACT = 8'h08;
  localparam logic [7:0] A_FRAME_AUX_PULSE_1 = 8'h09;
  localparam logic [7:0] A_FRAME_AUX_PULSE_2 = 8'h0A;
  localparam logic [7:0] A_IRQSEL = 8'h0B;
  localparam logic [7:0] A_AUXOUT = 8'h0C;
  localparam logic [7:0] A_EXCL = 8'h0D;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_TACH = 8'h11;
  localparam logic [7:0] A_LCAP = 8'h12;
  localparam logic [7:0] A_FCAP = 8'h13;
  localparam logic [7:0] A_CMD = 8'h14;
  // Control fields
  localparam int C_HSRC = 0;   // 2 bits: 0 free,1 line sync,2 composite
  localparam int C_VSRC = 2;   // 2 bits vertical source
  localparam int C_STRIP = 4;  // strip equalization pulses
  localparam int C_INTER = 5;  // interlaced
  localparam int C_CONT = 6;   // continuous vertical (line scan)
  localparam int C_TRIG = 7;   // wait for fire command
  localparam int C_TACHS = 8;  // 2 bits tachometer input
  localparam int C_CAPS = 10;  // 2 bits capture event
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  typedef enum logic [1:0] {VS_FREE, VS_EXTSYNC, VS_EXTRESET, VS_SOFT} atg_vsrc_t;
  typedef enum logic [3:0] {
    IS_FRAME_AUX_PULSE_1, IS_FRAME_AUX_PULSE_2, IS_VACT_ON, IS_VACT_OFF, IS_STROBE, IS_HSYNC,
    IS_VSYNC_ON, IS_VSYNC_OFF, IS_AUX_RISE, IS_AUX_FALL, IS_SYNCERR,
    IS_FIFODONE, IS_AUXDIFF, IS_NONE
  } atg_isrc_t;
endpackage : atg_pkg

// file: sim/atg_properties.sv
// Checker: port properties of the acquisition timing generator
`timescale 1ns/1ps
`default_nettype none
module atg_checker (
  // Clock, reset and register port
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdData,
  // Timing, aux and interrupt outputs
  input wire logic        lineSyncOut,
  input wire logic        linePeriodPulse,
  input wire logic        frameActiveWindow,
  input wire logic        framePeriodPulse,
  input wire logic        auxOutputDiff,
  input wire logic        auxOutputSingleA,
  input wire logic        auxOutputSingleB,
  input wire logic [3:0]  irq
);
  logic [13:0] hPer;
  logic [15:0] irqSel, selOld;
  logic [14:0] gap;
  logic [7:0]  ctrl;
  logic [2:0]  auxVal;
  logic        armed, free;
  logic [3:0]  quiet;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Shadows; any write disarms period checks until the next wrap
  always_ff @(posedge clk) begin
    if (reset) begin
      hPer   <= 14'h0000;
      irqSel <= 16'hDDDD;
      selOld <= 16'hDDDD;
      gap    <= 15'h0000;
      ctrl   <= 8'h00;
      auxVal <= 3'h0;
      armed  <= 1'b0;
    end else begin
      selOld <= irqSel;
      gap    <= linePeriodPulse ? 15'h0001 : gap + 15'h0001;
      armed  <= regWrite ? 1'b0 : (armed | linePeriodPulse);
      if (regWrite && regAddr == atg_pkg::A_HPER) hPer <= regWrData[13:0];
      if (regWrite && regAddr == atg_pkg::A_CTRL) ctrl <= regWrData[7:0];
      if (regWrite && regAddr == atg_pkg::A_IRQSEL) irqSel <= regWrData[15:0];
      if (regWrite && regAddr == atg_pkg::A_AUXOUT) auxVal <= regWrData[2:0];
    end
  end
  // Selector settled on none for two cycles
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      quiet[i] = irqSel[4*i +: 4] == 4'hD && selOld[4*i +: 4] == 4'hD;
    end
  end
  assign free = ctrl == 8'h00 && armed && hPer != 14'h0000;
  sequence auxWrite;
    regWrite && regAddr == atg_pkg::A_AUXOUT;
  endsequence
  sequence lineWrap;
    linePeriodPulse && free;
  endsequence
  a_read_idle_zero: assert property (
    !$past(regRead) |-> regRdData == 32'h0000_0000)
    else $error("read data outside read cycle");
  a_reset_quiet: assert property (
    $past(reset) |-> !lineSyncOut && !linePeriodPulse && irq == 4'h0)
    else $error("outputs active after reset");
  a_aux_pins_follow: assert property (
    auxWrite |-> ##2
      {auxOutputSingleB, auxOutputSingleA, auxOutputDiff} == auxVal)
    else $error("aux pins differ from written value");
  a_line_period_len: assert property (
    lineWrap |-> gap == {1'b0, hPer} + 15'h0001)
    else $error("line period length wrong");
  a_line_pulse_one: assert property (
    lineWrap |=> !linePeriodPulse)
    else $error("line period pulse too long");
  a_frame_on_wrap: assert property (
    framePeriodPulse && free |-> linePeriodPulse || $past(linePeriodPulse))
    else $error("frame pulse away from line wrap");
  a_frame_pulse_one: assert property (
    framePeriodPulse && free |=> !framePeriodPulse)
    else $error("frame period pulse too long");
  a_frame_window_line: assert property (
    $changed(frameActiveWindow) && free |->
      linePeriodPulse || $past(linePeriodPulse))
    else $error("frame window moved mid line");
  a_irq_pulse_short: assert property (
    hPer != 14'h0000 |-> (irq & $past(irq)) == 4'h0)
    else $error("interrupt longer than one cycle");
  a_irq_none_quiet: assert property (
    (irq & quiet) == 4'h0)
    else $error("interrupt with no source selected");
endmodule // atg_checker
bind atg_top atg_checker chk_u (
  .clk, .reset, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
  .lineSyncOut, .linePeriodPulse, .frameActiveWindow, .framePeriodPulse,
  .auxOutputDiff, .auxOutputSingleA, .auxOutputSingleB, .irq
);
`default_nettype wire

// file: sim/atg_sensor_model.sv
// Sensor model: line sync pulses toward the timing generator
`timescale 1ns/1ps
`default_nettype none
module atg_sensor_model (
  // Clock and settings
  input  wire logic        clk,
  input  wire logic        enable,
  input  wire logic        strip,
  input  wire logic [15:0] width,
  input  wire logic [15:0] period,
  // Sync toward the device
  output logic             syncOut
);
  logic [15:0] phase;
  logic [15:0] minW;
  // Stripping needs long pulses, so never go below the receiver minimum
  assign minW = strip ? 16'(atg_pkg::HSYNC_LONG_CYC)
                      : 16'(atg_pkg::SEP_CYC);
  // Line stays low while disabled
  always_ff @(posedge clk) begin
    phase <= (!enable || phase >= period - 16'h0001) ? 16'h0000
                                                     : phase + 16'h0001;
    syncOut <= enable && (phase < width || phase < minW);
  end
endmodule // atg_sensor_model
`default_nettype wire

// file: sim/atg_top_tb.sv
// Bench: register-driven tests of the acquisition timing generator
`timescale 1ns/1ps
`default_nettype none
module atg_top_tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0000_0000;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic        strobeIn = 1'b0;
  logic        auxInputSingle = 1'b0;
  logic        tied = 1'b0;
  logic        modelOn = 1'b0;
  logic        strip = 1'b0;
  wire logic   syncIn;
  wire logic [31:0] regRdData;
  wire logic [14:0] watched;
  wire logic [2:0]  auxPins;
  int cnt [15];
  int d [15];
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  // Line 20 clocks, frame 4 lines; blanking 8 pixels and 2 lines
  localparam logic [39:0] TIMING [12] = '{
    {atg_pkg::A_HPER, 32'h0000_0013}, {atg_pkg::A_HSYNC, 32'h0004_0000},
    {atg_pkg::A_HACT, 32'h0010_0004},
    {atg_pkg::A_LINE_AUX_PULSE_1, 32'h0003_0002}, {atg_pkg::A_LINE_AUX_PULSE_2, 32'h0009_0005},
    {atg_pkg::A_VPER, 32'h0000_0003}, {atg_pkg::A_VSYNC, 32'h0001_0000},
    {atg_pkg::A_VACT, 32'h0003_0001},
    {atg_pkg::A_FRAME_AUX_PULSE_1, 32'h0001_0000}, {atg_pkg::A_FRAME_AUX_PULSE_2, 32'h0004_0002},
    {atg_pkg::A_EXCL, 32'h0003_0001},
    {atg_pkg::A_CMD, 32'h0000_0001}};
  localparam int EXP_T [10] = '{160, 480, 40, 40, 160, 400, 10, 200, 200, 400};
  localparam int EXP_I [13] = '{10, 10, 10, 10, 1, 40, 10, 10, 1, 1, 0, 1, 1};
  localparam logic [31:0] MODES [3] = '{32'h1, 32'h2, 32'h12};
  atg_top dut_u (
    .clk, .reset, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .lineSyncIn(syncIn), .compSyncIn(syncIn), .frameSyncIn(tied),
    .frameResetIn(tied), .strobeIn, .fireIn(tied), .auxInputDiff(strobeIn),
    .auxInputSingle, .fifoDone(auxInputSingle), .lineSyncOut(watched[0]),
    .lineActiveWindow(watched[1]), .linePeriodPulse(watched[2]),
    .lineAuxPulse1(watched[3]), .lineAuxPulse2(watched[4]),
    .frameActiveWindow(watched[5]), .framePeriodPulse(watched[6]),
    .frameSyncOut(watched[7]), .frameAuxPulse1(watched[8]),
    .frameAuxPulse2(watched[9]), .strobeInhibit(watched[14]),
    .auxOutputDiff(auxPins[0]), .auxOutputSingleA(auxPins[1]),
    .auxOutputSingleB(auxPins[2]), .irq(watched[13:10]));
  atg_sensor_model cam_u (.clk, .enable(modelOn), .strip,
    .width(16'h0004), .period(16'h001E), .syncOut(syncIn));
  // Clock
  initial begin
    forever #4 clk = ~clk;
  end
  // High-cycle tallies and the hang guard
  always @(posedge clk) begin
    foreach (cnt[i]) cnt[i] <= cnt[i] + int'(watched[i]);
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      results();
    end
  end
  task automatic chk(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] v);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk(regRdData === v, "read data");
    @(posedge clk);
  endtask
  // Whole periods only, so tallies do not depend on phase
  task automatic span(input int n);
    int s [15];
    #1 s = cnt;
    repeat (n) @(posedge clk);
    #1 foreach (d[i]) d[i] = cnt[i] - s[i];
  endtask
  task automatic results;
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(atg_pkg::A_CTRL, atg_pkg::CTRL_RST);
    rd(atg_pkg::A_IRQSEL, 32'h0000_DDDD);
    rd(8'hFF, atg_pkg::ZERO32);
    wr(atg_pkg::A_AUXOUT, 32'h0000_0005);
    #1 chk(auxPins === 3'b101, "aux pins");
    foreach (TIMING[i]) wr(TIMING[i][39:32], TIMING[i][31:0]);
    repeat (100) @(posedge clk);
    span(800);
    foreach (EXP_T[i]) chk(d[i] == EXP_T[i], "timing tally");
    chk(d[14] == 400, "strobe exclusion");
    for (int c = 0; c < 13; c++) begin
      wr(atg_pkg::A_IRQSEL, {16'h0000, {4{c[3:0]}}});
      repeat (40) @(posedge clk);
      fork
        span(800);
        begin
          repeat (100) @(posedge clk);
          auxInputSingle <= 1'b1;
          strobeIn <= 1'b1;
          repeat (10) @(posedge clk);
          auxInputSingle <= 1'b0;
          strobeIn <= 1'b0;
        end
      join
      for (int b = 10; b < 14; b++) chk(d[b] == EXP_I[c], "irq");
    end
    wr(atg_pkg::A_HPER, 32'h0000_0063);
    for (int m = 0; m < 3; m++) begin
      wr(atg_pkg::A_CTRL, MODES[m]);
      strip <= MODES[m][4];
      modelOn <= 1'b1;
      repeat (100) @(posedge clk);
      span(300);
      chk(d[0] == 40, "line sync lock");
    end
    results();
  end
endmodule // atg_top_tb
`default_nettype wire
